/* File: cmd_code_map.vh */
`ifndef CMD_CODE_MAP_VH
`define CMD_CODE_MAP_VH

`define REG_COMMAND 8'h00
`define REG_CLONE 8'h04
`define REG_CONTROL 8'h08
`define REG_STATUS 8'h0C
`define REG_ACTION 8'h10
`define REG_RESULT 8'h14

`define CODE_SAVE_SAFE 17'h003E8
`define CODE_SAVE_ALWAYS 17'h003E9
`define CODE_OPT_RESET 17'h0042E
`define CODE_DEF_STD 17'h004D1
`define CODE_DEF_US 17'h004DC
`define CODE_MODE_STD 17'h004E5
`define CODE_MODE_US 17'h004E6
`define CODE_MODE_STD_X 17'h004E7
`define CODE_MODE_US_X 17'h004E8
`define CODE_BOOT_DIFF 17'h007D1
`define CODE_SUPP_CLR 17'h02553
`define CODE_SUPP_SET 17'h025C2
`define CODE_RO_CLR 17'h02631
`define CODE_RO_SET 17'h026A0
`define CODE_CARD_ERASE 17'h0270F
`define CODE_NP_BASE 17'h02AF8
`define CODE_DISP_NONDEF 17'h02EE0
`define CODE_DISP_DEST 17'h02EE1

`define ACT_NONE 5'h00
`define ACT_SAVE 5'h01
`define ACT_OPT_RESET 5'h02
`define ACT_DEFAULTS 5'h03
`define ACT_MODE 5'h04
`define ACT_BOOT_DIFF 5'h05
`define ACT_CARD_FULL 5'h06
`define ACT_CARD_DIFF 5'h07
`define ACT_CARD_LADDER 5'h08
`define ACT_CARD_LOAD 5'h09
`define ACT_CARD_BERASE 5'h0A
`define ACT_CARD_COMPARE 5'h0B
`define ACT_CARD_ERASE 5'h0C
`define ACT_NAMEPLATE 5'h0D
`define ACT_FLAGS 5'h0E

`define CTL_UV_BIT 0
`define CTL_LV_BIT 1
`define CTL_EN_BIT 2
`define CTL_RSTREQ_BIT 3

`endif

/* File: drive_command_code_interpreter.v */
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cmd_code_map.vh"

// Operation
// - one command register for every menu index zero
// - 1000 saves only with both supply flags clear
// - 1001 saves regardless of supply flags
// - 1070 resets all option modules
// - 1253/1254 mode change, standard or US defaults
// - 1255/1256 same, menus 15-20 untouched
// - 2001 boot diff image block 1, clear selector
// - 3/4/5yyy copy full, diff, ladder to block
// - 6/7/8yyy load, erase, compare card block
// - 9555 clears, 9666 sets warning suppression
// - 9777 clears, 9888 sets read-only flag
// - 110zy starts nameplate transfer with target
// - 12000/12001 display filters act immediately
// - other codes wait for a drive reset
// - success clears the command word
// - refused action keeps word, no trip
// - failed action trips, keeps word
// - success clears selector only below 3, or after 2001
// - selector 1/2 yields to a valid command
// - selector 3/4 adds card write per save
// - reset request rising edge triggers drive reset
module drive_command_code_interpreter (
    input wire clk_in,
    input wire nrst_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg [31:0] hrdata_out,
    output reg hreadyout_out,
    output reg hresp_out,
    input wire engine_done_in,
    input wire engine_fail_in,
    output reg [4:0] action_out,
    output reg [9:0] action_block_out,
    output reg [3:0] action_variant_out,
    output reg action_start_out,
    output reg card_save_also_out,
    output reg busy_out,
    output reg trip_out,
    output reg warn_suppress_out,
    output reg card_readonly_out,
    output reg disp_nondefault_out,
    output reg disp_dest_out
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [16:0] command_reg;
    reg [2:0] clone_reg;
    reg [3:0] control_reg;
    reg [1:0] state_reg;
    reg rstreq_prev_reg;
    reg [7:0] addr_reg;
    reg wr_pend_reg;
    reg [5:0] np_off;
    reg [4:0] dec_act;
    reg [9:0] dec_blk;
    reg [3:0] dec_var;
    reg dec_refuse;
    reg [3:0] lead;
    reg [9:0] low3;
    reg [31:0] rd_next;

    wire addr_phase = hsel_in && hready_in && htrans_in[1];
    wire rst_edge = control_reg[`CTL_RSTREQ_BIT] && !rstreq_prev_reg;
    wire drive_en = control_reg[`CTL_EN_BIT];

    // decode of the leading digit without a divider chain for the 4-digit forms
    always @* begin
        dec_act = `ACT_NONE;
        dec_blk = 10'h000;
        dec_var = 4'h0;
        dec_refuse = 1'b0;
        lead = 4'h0;
        low3 = 10'h000;
        // offset from 11000 modulo 64, only 0..39 is ever used
        np_off = command_reg[5:0] - 6'h38;
        if (command_reg >= 17'd3000 && command_reg <= 17'd8999) begin
            if (command_reg < 17'd4000) begin
                lead = 4'd3;
                low3 = command_reg[9:0] - 10'd952;
            end else if (command_reg < 17'd5000) begin
                lead = 4'd4;
                low3 = command_reg[9:0] - 10'd928;
            end else if (command_reg < 17'd6000) begin
                lead = 4'd5;
                low3 = command_reg[9:0] - 10'd904;
            end else if (command_reg < 17'd7000) begin
                lead = 4'd6;
                low3 = command_reg[9:0] - 10'd880;
            end else if (command_reg < 17'd8000) begin
                lead = 4'd7;
                low3 = command_reg[9:0] - 10'd856;
            end else begin
                lead = 4'd8;
                low3 = command_reg[9:0] - 10'd832;
            end
        end
        case (command_reg)
            `CODE_SAVE_SAFE: begin
                dec_act = `ACT_SAVE;
                dec_refuse = control_reg[`CTL_UV_BIT] | control_reg[`CTL_LV_BIT];
            end
            `CODE_SAVE_ALWAYS: dec_act = `ACT_SAVE;
            `CODE_OPT_RESET: dec_act = `ACT_OPT_RESET;
            `CODE_DEF_STD, `CODE_DEF_US: begin
                dec_act = `ACT_DEFAULTS;
                dec_var = {3'b000, command_reg == `CODE_DEF_US};
                dec_refuse = drive_en;
            end
            `CODE_MODE_STD, `CODE_MODE_US, `CODE_MODE_STD_X, `CODE_MODE_US_X: begin
                dec_act = `ACT_MODE;
                // bit0 US defaults, bit1 keep menus 15-20
                dec_var = command_reg[3:0] - 4'h5;
                dec_refuse = drive_en;
            end
            `CODE_BOOT_DIFF: begin
                dec_act = `ACT_BOOT_DIFF;
                dec_blk = 10'h001;
            end
            `CODE_SUPP_CLR, `CODE_SUPP_SET, `CODE_RO_CLR, `CODE_RO_SET:
                dec_act = `ACT_FLAGS;
            `CODE_CARD_ERASE: dec_act = `ACT_CARD_ERASE;
            default: begin
                if (lead != 4'h0) begin
                    dec_act = `ACT_CARD_FULL + {1'b0, lead} - 5'd3;
                    dec_blk = low3;
                end else if (command_reg >= `CODE_NP_BASE &&
                             command_reg <= `CODE_NP_BASE + 17'd39) begin
                    dec_act = `ACT_NAMEPLATE;
                    // z digit to variant, y digit to block
                    if (np_off >= 6'h1E) begin
                        dec_var = 4'h3;
                        dec_blk = {4'h0, np_off - 6'h1E};
                    end else if (np_off >= 6'h14) begin
                        dec_var = 4'h2;
                        dec_blk = {4'h0, np_off - 6'h14};
                    end else if (np_off >= 6'h0A) begin
                        dec_var = 4'h1;
                        dec_blk = {4'h0, np_off - 6'h0A};
                    end else begin
                        dec_blk = {4'h0, np_off};
                    end
                end
            end
        endcase
    end

    always @* begin
        // muxed from the address phase so the word stands through the data phase
        case ({haddr_in[7:2], 2'b00})
            `REG_COMMAND: rd_next = {15'h0000, command_reg};
            `REG_CLONE: rd_next = {29'h0, clone_reg};
            `REG_CONTROL: rd_next = {28'h0, control_reg};
            `REG_STATUS: rd_next = {25'h0, disp_dest_out, disp_nondefault_out,
                                    card_readonly_out, warn_suppress_out,
                                    trip_out, busy_out, card_save_also_out};
            `REG_ACTION: rd_next = {12'h000, action_variant_out, action_block_out,
                                    1'b0, action_out};
            default: rd_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            command_reg <= 17'h00000;
            clone_reg <= 3'h0;
            control_reg <= 4'h0;
            state_reg <= ST_IDLE;
            rstreq_prev_reg <= 1'b0;
            addr_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            hrdata_out <= 32'h00000000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            action_out <= `ACT_NONE;
            action_block_out <= 10'h000;
            action_variant_out <= 4'h0;
            action_start_out <= 1'b0;
            card_save_also_out <= 1'b0;
            busy_out <= 1'b0;
            trip_out <= 1'b0;
            warn_suppress_out <= 1'b0;
            card_readonly_out <= 1'b0;
            disp_nondefault_out <= 1'b0;
            disp_dest_out <= 1'b0;
        end else begin
            action_start_out <= 1'b0;
            rstreq_prev_reg <= control_reg[`CTL_RSTREQ_BIT];
            wr_pend_reg <= addr_phase && hwrite_in;
            if (addr_phase)
                addr_reg <= {haddr_in[7:2], 2'b00};
            // zero wait: data must stand before the data-phase edge;
            // a read pipelined right behind a write sees the old word
            if (addr_phase && !hwrite_in)
                hrdata_out <= rd_next;
            else
                hrdata_out <= 32'h00000000;
            card_save_also_out <= clone_reg == 3'd3 || clone_reg == 3'd4;
            if (rst_edge)
                trip_out <= 1'b0;
            if (wr_pend_reg) begin
                case (addr_reg)
                    // the single command word is what every menu's index zero maps onto
                    `REG_COMMAND: begin
                        command_reg <= hwdata_in[16:0];
                        if (hwdata_in[16:0] == `CODE_DISP_NONDEF) begin
                            disp_nondefault_out <= 1'b1;
                            disp_dest_out <= 1'b0;
                        end else if (hwdata_in[16:0] == `CODE_DISP_DEST) begin
                            disp_dest_out <= 1'b1;
                            disp_nondefault_out <= 1'b0;
                        end else begin
                            disp_nondefault_out <= 1'b0;
                            disp_dest_out <= 1'b0;
                        end
                    end
                    `REG_CLONE: begin
                        clone_reg <= hwdata_in[2:0];
                        // no one-cycle lag for a status read just behind the write
                        card_save_also_out <= hwdata_in[2:0] == 3'h3 ||
                                              hwdata_in[2:0] == 3'h4;
                    end
                    `REG_CONTROL: control_reg <= hwdata_in[3:0];
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE: begin
                    // only a reset edge launches anything here
                    if (rst_edge && dec_act != `ACT_NONE && !dec_refuse) begin
                        if (dec_act == `ACT_FLAGS) begin
                            // flag codes finish at once, no engine involved
                            if (command_reg == `CODE_SUPP_CLR)
                                warn_suppress_out <= 1'b0;
                            if (command_reg == `CODE_SUPP_SET)
                                warn_suppress_out <= 1'b1;
                            if (command_reg == `CODE_RO_CLR)
                                card_readonly_out <= 1'b0;
                            if (command_reg == `CODE_RO_SET)
                                card_readonly_out <= 1'b1;
                            command_reg <= 17'h00000;
                            if (clone_reg < 3'd3)
                                clone_reg <= 3'h0;
                        end else begin
                            action_out <= dec_act;
                            action_block_out <= dec_blk;
                            action_variant_out <= dec_var;
                            action_start_out <= 1'b1;
                            busy_out <= 1'b1;
                            state_reg <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (engine_fail_in) begin
                        trip_out <= 1'b1;
                        busy_out <= 1'b0;
                        action_out <= `ACT_NONE;
                        state_reg <= ST_IDLE;
                    end else if (engine_done_in) begin
                        command_reg <= 17'h00000;
                        if (clone_reg < 3'd3 || action_out == `ACT_BOOT_DIFF)
                            clone_reg <= 3'h0;
                        busy_out <= 1'b0;
                        action_out <= `ACT_NONE;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: cmd_chk.sv */
`timescale 1ns/1ps
module cmd_chk (
    input wire clk_in,
    input wire nrst_in,
    input wire engine_done_in,
    input wire engine_fail_in,
    input wire [4:0] action_out,
    input wire action_start_out,
    input wire busy_out,
    input wire trip_out,
    input wire hreadyout_out,
    input wire hresp_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    bus_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("bus answer not zero-wait okay");
    start_pulse_a: assert property (action_start_out |=> !action_start_out)
        else $error("start pulse longer than one cycle");
    start_idle_a: assert property (action_start_out |-> !$past(busy_out))
        else $error("start while engine busy");
    act_set_a: assert property ($rose(busy_out) |-> action_out != 5'h00)
        else $error("busy with no action code");
    act_stable_a: assert property (busy_out && $past(busy_out) |-> $stable(action_out))
        else $error("action code changed while busy");
    busy_hold_a: assert property (busy_out && !engine_done_in && !engine_fail_in |=> busy_out)
        else $error("busy dropped without engine answer");
    done_clear_a: assert property (busy_out && engine_done_in && !engine_fail_in
        |=> !busy_out && !trip_out)
        else $error("success did not finish cleanly");
    fail_trip_a: assert property (busy_out && engine_fail_in |=> trip_out && !busy_out)
        else $error("failure did not trip");
    trip_cause_a: assert property ($rose(trip_out) |-> $past(busy_out) && $past(engine_fail_in))
        else $error("trip without a failed action");
    busy_end_a: assert property ($fell(busy_out) |-> $past(engine_done_in) || $past(engine_fail_in))
        else $error("busy ended without engine answer");
endmodule
bind drive_command_code_interpreter cmd_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .engine_done_in(engine_done_in), .engine_fail_in(engine_fail_in), .action_out(action_out),
    .action_start_out(action_start_out), .busy_out(busy_out), .trip_out(trip_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out));

/* File: tb.sv */
`timescale 1ns/1ps
`include "cmd_code_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
    reg clk_in = 0, nrst_in = 0, hsel_in = 0, hwrite_in = 0, rd_pend = 0;
    reg engine_done_in = 0, engine_fail_in = 0;
    reg [31:0] haddr_in = 0, hwdata_in = 0, e = 0, ctl = 0;
    reg [1:0] htrans_in = 0;
    reg [2:0] hsize_in = 3'h2;
    wire [31:0] hrdata_out;
    wire hreadyout_out, hresp_out, action_start_out, card_save_also_out, busy_out, trip_out;
    wire warn_suppress_out, card_readonly_out, disp_nondefault_out, disp_dest_out;
    wire [4:0] action_out;
    wire [9:0] action_block_out;
    wire [3:0] action_variant_out;
    int bad_count = 0, num_checks = 0, starts = 0, y, z;
    logic [31:0] exp_q[$];
    drive_command_code_interpreter DUT (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .engine_done_in(engine_done_in),
        .engine_fail_in(engine_fail_in), .action_out(action_out),
        .action_block_out(action_block_out), .action_variant_out(action_variant_out),
        .action_start_out(action_start_out), .card_save_also_out(card_save_also_out),
        .busy_out(busy_out), .trip_out(trip_out), .warn_suppress_out(warn_suppress_out),
        .card_readonly_out(card_readonly_out), .disp_nondefault_out(disp_nondefault_out),
        .disp_dest_out(disp_dest_out));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // oldest note is matched against read data at the data-phase edge
    always @(posedge clk_in) begin
        if (action_start_out === 1'b1) starts++;
        if (rd_pend) begin
            e = exp_q.pop_front();
            `CHK("hrdata", e, hrdata_out)
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_in);
        end
        if (n >= 50) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    // hsel and htrans drop after the address phase, only rd_pend at the end, so back-to-back calls assign each signal once per step
    task automatic xfer(input bit wr, input [7:0] a, input [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, a};
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        wait_rdy();
        htrans_in <= 2'h0;
        hsel_in <= 1'b0;
        hwdata_in <= d;
        rd_pend <= !wr;
        wait_rdy();
        rd_pend <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [31:0] x);
        exp_q.push_back(x);
        xfer(1'b0, a, 32'h0);
    endtask
    // res: 0 refused or ignored, 1 engine done, 2 engine fail, 3 no engine
    task automatic launch(input [16:0] code, input [31:0] act, input int res);
        int s;
        xfer(1'b1, `REG_COMMAND, {15'h0, code});
        xfer(1'b1, `REG_CONTROL, ctl);
        s = starts;
        xfer(1'b1, `REG_CONTROL, ctl | 32'h8);
        repeat (4) @(posedge clk_in);
        if (res != 3) `CHK("start", (res != 0), (starts - s == 1))
        if (res == 1 || res == 2) begin
            rd(`REG_ACTION, act);
            engine_done_in <= (res == 1);
            engine_fail_in <= (res == 2);
            @(posedge clk_in);
            engine_done_in <= 1'b0;
            engine_fail_in <= 1'b0;
            @(posedge clk_in);
        end
        rd(`REG_COMMAND, (res == 1 || res == 3) ? 32'h0 : {15'h0, code});
    endtask
    initial begin
        void'($urandom(67));
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(`REG_STATUS, 32'h0);
        ctl = 32'h1;
        launch(`CODE_SAVE_SAFE, 0, 0);
        launch(`CODE_SAVE_ALWAYS, `ACT_SAVE, 1);
        ctl = 32'h2;
        launch(`CODE_SAVE_SAFE, 0, 0);
        ctl = 32'h4;
        launch(`CODE_DEF_STD, 0, 0);
        launch(`CODE_MODE_US_X, 0, 0);
        ctl = 32'h0;
        launch(`CODE_SAVE_SAFE, `ACT_SAVE, 1);
        launch(17'd1234, 0, 0);
        $display("test supply and refusal done");
        for (int v = 0; v < 4; v++) launch(17'd1253 + v, {12'h0, v[3:0], 16'h4}, 1);
        for (int v = 0; v < 2; v++) launch(17'd1233 + 11 * v, {12'h0, v[3:0], 16'h3}, 1);
        launch(`CODE_OPT_RESET, `ACT_OPT_RESET, 1);
        for (int i = 0; i < 6; i++) begin
            y = $urandom % 1000;
            launch((3 + i) * 1000 + y, {16'h0, y[9:0], 6'h6 + i[5:0]}, 1);
        end
        launch(`CODE_CARD_ERASE, `ACT_CARD_ERASE, 1);
        y = $urandom % 10;
        z = $urandom % 4;
        launch(11000 + z * 10 + y, {12'h0, z[3:0], y[9:0], 6'h0D}, 1);
        $display("test action codes done");
        launch(`CODE_OPT_RESET, `ACT_OPT_RESET, 2);
        rd(`REG_STATUS, 32'h4);
        xfer(1'b1, `REG_CLONE, 32'h2);
        launch(`CODE_SAVE_ALWAYS, `ACT_SAVE, 1);
        rd(`REG_CLONE, 32'h0);
        xfer(1'b1, `REG_CLONE, 32'h3);
        rd(`REG_STATUS, 32'h1);
        launch(`CODE_SAVE_ALWAYS, `ACT_SAVE, 1);
        rd(`REG_CLONE, 32'h3);
        launch(`CODE_BOOT_DIFF, {16'h0, 10'h1, 6'h5}, 1);
        rd(`REG_CLONE, 32'h0);
        $display("test fail and selector done");
        launch(17'd9666, 0, 3);
        rd(`REG_STATUS, 32'h8);
        launch(17'd9888, 0, 3);
        rd(`REG_STATUS, 32'h18);
        launch(`CODE_SUPP_CLR, 0, 3);
        launch(`CODE_RO_CLR, 0, 3);
        rd(`REG_STATUS, 32'h0);
        xfer(1'b1, `REG_COMMAND, {15'h0, `CODE_DISP_NONDEF});
        rd(`REG_STATUS, 32'h20);
        xfer(1'b1, `REG_COMMAND, {15'h0, `CODE_DISP_DEST});
        rd(`REG_STATUS, 32'h40);
        $display("test flags and display done");
        report_and_stop();
    end
endmodule
